// ### rtl/cfmfc_cfg.svh
// constants of the message buffer control block: selectors, field positions, reset values
// assumes inclusion by the top design file of the block
`ifndef CFMFC_CFG_SVH
`define CFMFC_CFG_SVH

// register selector in addr[1:0], buffer number in addr[4:2]
`define CFMFC_SEL_CFGHI    2'h0
`define CFMFC_SEL_CTRLLO   2'h1
`define CFMFC_SEL_STATUS   2'h2
`define CFMFC_GLOBAL_BUF   3'h0

// configuration high word
`define CFMFC_PAYLOAD_SIZE_LSB   13
`define CFMFC_DEPTH_LSB    8
`define CFMFC_RETRY_ATTEMPTS_LSB     5
`define CFMFC_PRI_LSB      0
`define CFMFC_CFGHI_RST    16'h0060

// control low word
`define CFMFC_BIT_RESET    10
`define CFMFC_BIT_SENDREQ  9
`define CFMFC_BIT_INC      8
`define CFMFC_BIT_DIR      7
`define CFMFC_BIT_RTR      6
`define CFMFC_BIT_TS       5
`define CFMFC_BIT_ATIE     4
`define CFMFC_BIT_OVIE     3
`define CFMFC_CTRLEN_RST   8'h00
`define CFMFC_BUFRST_RST   1'b1

// status word
`define CFMFC_IDX_LSB      8
`define CFMFC_BIT_ABT      7
`define CFMFC_BIT_ARB      6
`define CFMFC_BIT_ERR      5
`define CFMFC_BIT_ATIF     4
`define CFMFC_BIT_OVIF     3

// global register (buffer slot 0)
`define CFMFC_MODE_CONFIG  3'h4
`define CFMFC_MODE_RST     3'h4
`define CFMFC_BIT_RLE      3
`define CFMFC_BIT_TXQE     2
`define CFMFC_BIT_TXQN     0

`endif

// ### rtl/cfmfc_pkg.sv
// types shared by the message buffer control block
// assumes nothing beyond a SystemVerilog compiler
package cfmfc_pkg;

   typedef enum logic [1:0] {
      CFMFC_RETRY_NONE  = 2'b00,
      CFMFC_RETRY_THREE = 2'b01,
      CFMFC_RETRY_UNLIM = 2'b10
   } cfmfc_retry_t;

   // per-buffer events from the protocol engine, one-cycle pulses
   typedef struct packed {
      logic txDone;        // message sent successfully
      logic abortDone;     // pending message aborted
      logic busErr;        // level, valid with txDone or abortDone
      logic lostArb;       // level, valid with txDone or abortDone
      logic attemptsOut;   // transmit attempts exhausted
      logic rxStore;       // message stored in the buffer
      logic rtrRx;         // remote request received for this buffer
   } cfmfc_evt_t;

   // per-buffer settings toward the protocol engine and message ram
   typedef struct packed {
      logic         isTx;
      logic         sendRequest;
      logic         abortReq;
      logic         tsEnable;
      logic [6:0]   payloadBytes;
      logic [4:0]   depthCode;
      logic [4:0]   txPriority;
      cfmfc_retry_t retry;
      logic [4:0]   msgIndex;
      logic         irq;
   } cfmfc_bufcfg_t;

endpackage

// ### rtl/cfmfc_occupancy.sv
// occupancy counter and message index of one buffer
// assumes push and pop are single-cycle pulses on clk
`timescale 1ns/10ps
module cfmfc_occupancy
(
   // clock and reset
   input  wire logic       clk,
   input  wire logic       nrst,
   // control
   input  wire logic       clr,
   input  wire logic       push,
   input  wire logic       pop,
   input  wire logic       idxOnPush,
   input  wire logic [4:0] depthCode,
   // state
   output logic      [5:0] count,
   output logic      [4:0] index,
   output logic            full,
   output logic            empty,
   output logic            halfUp,
   output logic            halfDown
);
   logic [5:0] depth;
   logic       doPush;
   logic       doPop;
   logic       step;

   assign depth    = {1'b0, depthCode} + 6'h01;
   assign full     = (count == depth);
   assign empty    = (count == 6'h00);
   // twice the count against the depth: avoids losing the odd half
   assign halfUp   = ({count, 1'b0} >= {1'b0, depth});
   assign halfDown = ({count, 1'b0} <= {1'b0, depth});
   assign doPush   = push && !full;
   assign doPop    = pop && !empty;
   assign step     = idxOnPush ? doPush : doPop;

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         count <= 6'h00;
      else if (clr)
         count <= 6'h00;
      else if (doPush && !doPop)
         count <= count + 6'h01;
      else if (doPop && !doPush)
         count <= count - 6'h01;
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         index <= 5'h00;
      else if (clr)
         index <= 5'h00;
      else if (step)
      begin
         if (index >= depthCode)
            index <= 5'h00;
         else
            index <= index + 5'h01;
      end
   end
endmodule

// ### rtl/cfmfc_txq_flags.sv
// empty and not-full flags of the transmit queue
// assumes count and depth come from logic on clk
`timescale 1ns/10ps
module cfmfc_txq_flags
(
   // clock and reset
   input  wire logic       clk,
   input  wire logic       nrst,
   // queue state
   input  wire logic [5:0] qCount,
   input  wire logic [4:0] qDepthCode,
   // flags
   output logic            queueEmptyFlag,
   output logic            queueNotFullFlag
);
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         queueEmptyFlag   <= 1'b1;
         queueNotFullFlag <= 1'b1;
      end
      else
      begin
         queueEmptyFlag   <= (qCount == 6'h00);
         queueNotFullFlag <= (qCount < ({1'b0, qDepthCode} + 6'h01));
      end
   end
endmodule

// ### rtl/cfmfc_top.sv
// control and status of the message buffers of a can fd controller
// assumes engine events are on clk and registers are reached over a plain port
`timescale 1ns/10ps
`include "cfmfc_cfg.svh"
module cfmfc_top
#(
   parameter int NBUF = 7
)
(
   // clock and reset
   input  wire logic                                clk,
   input  wire logic                                nrst,
   // register port
   input  wire logic [4:0]                          addr,
   input  wire logic [15:0]                         wrData,
   input  wire logic                                wrEn,
   input  wire logic                                rdEn,
   output logic      [15:0]                         rdData,
   // protocol engine side
   input  wire cfmfc_pkg::cfmfc_evt_t [NBUF:1]      evt,
   input  wire logic [5:0]                          txqCount,
   input  wire logic [4:0]                          txqDepthCode,
   output cfmfc_pkg::cfmfc_bufcfg_t [NBUF:1]        bufCfg,
   output logic      [2:0]                          nextTxBuf,
   output logic                                     nextTxValid
);
   import cfmfc_pkg::*;

   logic [2:0]  modeField_r;
   logic        retryLimitEnable_r;
   logic        cfgMode;
   logic        queueEmptyFlag;
   logic        queueNotFullFlag;
   logic [15:0] cfgWord  [NBUF:1];
   logic [15:0] ctrlWord [NBUF:1];
   logic [15:0] statWord [NBUF:1];
   logic [4:0]  prioOf   [NBUF:1];
   logic        pendOf   [NBUF:1];
   logic [2:0]  bestBuf;
   logic        bestValid;
   logic [4:0]  bestPri;
   logic [15:0] rdWord;
   logic        globalSel;

   assign cfgMode   = (modeField_r == `CFMFC_MODE_CONFIG);
   assign globalSel = (addr[4:2] == `CFMFC_GLOBAL_BUF);

   function automatic logic [6:0] payloadOf(input logic [2:0] code);
      case (code)
         3'h0:    payloadOf = 7'h08;
         3'h1:    payloadOf = 7'h0c;
         3'h2:    payloadOf = 7'h10;
         3'h3:    payloadOf = 7'h14;
         3'h4:    payloadOf = 7'h18;
         3'h5:    payloadOf = 7'h20;
         3'h6:    payloadOf = 7'h30;
         default: payloadOf = 7'h40;
      endcase
   endfunction

   function automatic cfmfc_retry_t retryOf(input logic en, input logic [1:0] code);
      // without the global limit the engine retries without end
      if (!en)
         retryOf = CFMFC_RETRY_UNLIM;
      else if (code == 2'b00)
         retryOf = CFMFC_RETRY_NONE;
      else if (code == 2'b01)
         retryOf = CFMFC_RETRY_THREE;
      else
         retryOf = CFMFC_RETRY_UNLIM;
   endfunction

   // global mode and limit enable
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         modeField_r        <= `CFMFC_MODE_RST;
         retryLimitEnable_r <= 1'b0;
      end
      else if (wrEn && globalSel && addr[1:0] == `CFMFC_SEL_CFGHI)
      begin
         modeField_r        <= wrData[2:0];
         retryLimitEnable_r <= wrData[`CFMFC_BIT_RLE];
      end
   end

   cfmfc_txq_flags u_txq
   (
      .clk              (clk),
      .nrst             (nrst),
      .qCount           (txqCount),
      .qDepthCode       (txqDepthCode),
      .queueEmptyFlag   (queueEmptyFlag),
      .queueNotFullFlag (queueNotFullFlag)
   );

   genvar g;
   generate
      for (g = 1; g <= NBUF; g++)
      begin : gBuf
         logic [15:0] cfgHi_r;
         logic [7:0]  ctrlEn_r;
         logic        bufReset_r;
         logic        sendReq_r;
         logic        aborted_r;
         logic        lostArb_r;
         logic        busErr_r;
         logic        attempts_r;
         logic        overflow_r;
         logic        sel;
         logic        wrCfg;
         logic        wrCtrl;
         logic        wrStat;
         logic        rdStat;
         logic        isTx;
         logic        incPulse;
         logic        reqSet;
         logic        lastSent;
         logic        abortAsk;
         logic [5:0]  count;
         logic [4:0]  index;
         logic        full;
         logic        empty;
         logic        halfUp;
         logic        halfDown;
         logic [2:0]  occFlags;
         logic        irq;

         assign sel      = (addr[4:2] == 3'(g));
         assign wrCfg    = wrEn && sel && addr[1:0] == `CFMFC_SEL_CFGHI;
         assign wrCtrl   = wrEn && sel && addr[1:0] == `CFMFC_SEL_CTRLLO;
         assign wrStat   = wrEn && sel && addr[1:0] == `CFMFC_SEL_STATUS;
         assign rdStat   = rdEn && sel && addr[1:0] == `CFMFC_SEL_STATUS;
         assign isTx     = ctrlEn_r[`CFMFC_BIT_DIR];
         assign incPulse = wrCtrl && wrData[`CFMFC_BIT_INC];
         assign reqSet   = isTx && ((wrCtrl && wrData[`CFMFC_BIT_SENDREQ])
                           || (evt[g].rtrRx && ctrlEn_r[`CFMFC_BIT_RTR]));
         assign lastSent = evt[g].txDone && count == 6'h01;
         assign abortAsk = isTx && wrCtrl && sendReq_r
                           && !wrData[`CFMFC_BIT_SENDREQ];

         // occupancy: head and tail swap roles with direction
         cfmfc_occupancy u_occ
         (
            .clk       (clk),
            .nrst      (nrst),
            .clr       (bufReset_r),
            .push      (isTx ? incPulse : evt[g].rxStore),
            .pop       (isTx ? evt[g].txDone : incPulse),
            .idxOnPush (!isTx),
            .depthCode (cfgHi_r[`CFMFC_DEPTH_LSB +: 5]),
            .count     (count),
            .index     (index),
            .full      (full),
            .empty     (empty),
            .halfUp    (halfUp),
            .halfDown  (halfDown)
         );

         // size fields locked outside configuration mode
         always_ff @(posedge clk or negedge nrst)
         begin
            if (!nrst)
               cfgHi_r <= `CFMFC_CFGHI_RST;
            else if (wrCfg)
               cfgHi_r <= {cfgMode ? wrData[15:8] : cfgHi_r[15:8], 1'b0, wrData[6:0]};
         end

         always_ff @(posedge clk or negedge nrst)
         begin
            if (!nrst)
               ctrlEn_r <= `CFMFC_CTRLEN_RST;
            else if (wrCtrl)
            begin
               ctrlEn_r <= wrData[7:0];
               if (!cfgMode)
                  ctrlEn_r[`CFMFC_BIT_TS] <= ctrlEn_r[`CFMFC_BIT_TS];
            end
         end

         // reset runs for one cycle, then the bit drops
         always_ff @(posedge clk or negedge nrst)
         begin
            if (!nrst)
               bufReset_r <= `CFMFC_BUFRST_RST;
            else
               bufReset_r <= wrCtrl && wrData[`CFMFC_BIT_RESET];
         end

         // set beats the clear from the engine in the same cycle
         always_ff @(posedge clk or negedge nrst)
         begin
            if (!nrst)
               sendReq_r <= 1'b0;
            else if (bufReset_r || !isTx)
               sendReq_r <= 1'b0;
            else if (reqSet)
               sendReq_r <= 1'b1;
            else if (lastSent || evt[g].abortDone)
               sendReq_r <= 1'b0;
         end

         always_ff @(posedge clk or negedge nrst)
         begin
            if (!nrst)
               aborted_r <= 1'b0;
            else if (isTx && evt[g].abortDone)
               aborted_r <= 1'b1;
            else if (rdStat || bufReset_r || reqSet || evt[g].txDone)
               aborted_r <= 1'b0;
         end

         always_ff @(posedge clk or negedge nrst)
         begin
            if (!nrst)
            begin
               lostArb_r <= 1'b0;
               busErr_r  <= 1'b0;
            end
            else if (bufReset_r)
            begin
               lostArb_r <= 1'b0;
               busErr_r  <= 1'b0;
            end
            else if (evt[g].txDone || evt[g].abortDone)
            begin
               lostArb_r <= evt[g].lostArb;
               busErr_r  <= evt[g].busErr;
            end
         end

         always_ff @(posedge clk or negedge nrst)
         begin
            if (!nrst)
               attempts_r <= 1'b0;
            else if (isTx && evt[g].attemptsOut)
               attempts_r <= 1'b1;
            else if (bufReset_r || (wrStat && !wrData[`CFMFC_BIT_ATIF]))
               attempts_r <= 1'b0;
         end

         always_ff @(posedge clk or negedge nrst)
         begin
            if (!nrst)
               overflow_r <= 1'b0;
            else if (!isTx && evt[g].rxStore && full)
               overflow_r <= 1'b1;
            else if (bufReset_r || (wrStat && !wrData[`CFMFC_BIT_OVIF]))
               overflow_r <= 1'b0;
         end

         assign occFlags = isTx ? {empty, halfDown, !full}
                                : {full, halfUp, !empty};
         assign irq = |{occFlags & ctrlEn_r[2:0],
                        attempts_r & isTx & ctrlEn_r[`CFMFC_BIT_ATIE],
                        overflow_r & !isTx & ctrlEn_r[`CFMFC_BIT_OVIE]};

         assign cfgWord[g]  = cfgHi_r;
         assign ctrlWord[g] = {5'h00, bufReset_r, sendReq_r, 1'b0, ctrlEn_r};
         assign statWord[g] = {3'h0, index,
                               isTx ? {aborted_r, lostArb_r, busErr_r, attempts_r} : 4'h0,
                               overflow_r & !isTx, occFlags};
         assign prioOf[g]   = cfgHi_r[`CFMFC_PRI_LSB +: 5];
         assign pendOf[g]   = isTx && sendReq_r;

         // engine settings, one cycle behind the registers
         always_ff @(posedge clk or negedge nrst)
         begin
            if (!nrst)
               bufCfg[g] <= '0;
            else
            begin
               bufCfg[g].isTx         <= isTx;
               bufCfg[g].sendRequest  <= sendReq_r;
               bufCfg[g].abortReq     <= abortAsk;
               bufCfg[g].tsEnable     <= !isTx && ctrlEn_r[`CFMFC_BIT_TS];
               bufCfg[g].payloadBytes <= payloadOf(cfgHi_r[`CFMFC_PAYLOAD_SIZE_LSB +: 3]);
               bufCfg[g].depthCode    <= cfgHi_r[`CFMFC_DEPTH_LSB +: 5];
               bufCfg[g].txPriority   <= cfgHi_r[`CFMFC_PRI_LSB +: 5];
               bufCfg[g].retry        <= retryOf(retryLimitEnable_r,
                                                 cfgHi_r[`CFMFC_RETRY_ATTEMPTS_LSB +: 2]);
               bufCfg[g].msgIndex     <= index;
               bufCfg[g].irq          <= irq;
            end
         end
      end
   endgenerate

   // highest priority pending buffer; lower number wins a tie
   always_comb
   begin
      bestBuf   = 3'h0;
      bestValid = 1'b0;
      bestPri   = 5'h00;
      for (int i = 1; i <= NBUF; i++)
      begin
         if (pendOf[i] && (!bestValid || prioOf[i] > bestPri))
         begin
            bestBuf   = 3'(i);
            bestValid = 1'b1;
            bestPri   = prioOf[i];
         end
      end
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         nextTxBuf   <= 3'h0;
         nextTxValid <= 1'b0;
      end
      else
      begin
         nextTxBuf   <= bestBuf;
         nextTxValid <= bestValid;
      end
   end

   // read mux; unmapped addresses read zero
   always_comb
   begin
      rdWord = 16'h0000;
      if (globalSel && addr[1:0] == `CFMFC_SEL_CFGHI)
         rdWord = {12'h000, retryLimitEnable_r, modeField_r};
      else if (globalSel && addr[1:0] == `CFMFC_SEL_STATUS)
      begin
         rdWord[`CFMFC_BIT_TXQE] = queueEmptyFlag;
         rdWord[`CFMFC_BIT_TXQN] = queueNotFullFlag;
      end
      else if (!globalSel && int'(addr[4:2]) <= NBUF)
      begin
         if (addr[1:0] == `CFMFC_SEL_CFGHI)
            rdWord = cfgWord[addr[4:2]];
         else if (addr[1:0] == `CFMFC_SEL_CTRLLO)
            rdWord = ctrlWord[addr[4:2]];
         else if (addr[1:0] == `CFMFC_SEL_STATUS)
            rdWord = statWord[addr[4:2]];
      end
   end

   // data stand only in the cycle after the strobe
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         rdData <= 16'h0000;
      else if (rdEn)
         rdData <= rdWord;
      else
         rdData <= 16'h0000;
   end
endmodule

// ### tb/cfmfc_engine_model.sv
// protocol engine stand-in: event pulses, late abort answers, queue levels
// assumes the bench calls pulse() and sets levels through hierarchy
`timescale 1ns/10ps
module cfmfc_engine_model
#(
   parameter int NBUF = 7
)
(
   // clock
   input  wire logic                             clk,
   // buffer settings seen by the engine
   input  wire cfmfc_pkg::cfmfc_bufcfg_t [NBUF:1] bufCfg,
   // engine outputs
   output cfmfc_pkg::cfmfc_evt_t [NBUF:1]        evt,
   output logic [5:0]                            txqCount,
   output logic [4:0]                            txqDepthCode
);
   import cfmfc_pkg::*;
   int   abortLag = 3;
   logic errLvl = 1'b0;
   logic arbLvl = 1'b1;
   initial
   begin
      evt = '0;
      txqCount = 6'h00;
      txqDepthCode = 5'h03;
   end
   task automatic pulse(input int b, input cfmfc_evt_t e);
      @(posedge clk);
      evt[b] <= e;
      @(posedge clk);
      evt[b] <= '0;
   endtask
   // a busy bus answers an abort only after a few cycles
   always @(posedge clk)
      for (int b = 1; b <= NBUF; b++)
         if (bufCfg[b].abortReq)
         begin
            repeat (abortLag) @(posedge clk);
            pulse(b, {1'b0, 1'b1, errLvl, arbLvl, 3'h0});
         end
endmodule

// ### tb/cfmfc_top_chk.sv
// assertions on the ports of the message buffer control block
// assumes a bind to cfmfc_top from the bench top file
`timescale 1ns/10ps
module cfmfc_top_chk
#(
   parameter int NBUF = 7
)
(
   // clock, reset and register port
   input wire logic                             clk,
   input wire logic                             nrst,
   input wire logic [4:0]                       addr,
   input wire logic                             rdEn,
   input wire logic [15:0]                      rdData,
   // engine side
   input wire cfmfc_pkg::cfmfc_evt_t [NBUF:1]    evt,
   input wire logic [5:0]                       txqCount,
   input wire logic [4:0]                       txqDepthCode,
   input wire cfmfc_pkg::cfmfc_bufcfg_t [NBUF:1] bufCfg
);
   import cfmfc_pkg::*;
   logic       stRd_r;
   logic       glRd_r;
   logic [2:0] rdBuf_r;
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   always_ff @(posedge clk or negedge nrst)
      if (!nrst)
      begin
         stRd_r <= 1'b0;
         glRd_r <= 1'b0;
         rdBuf_r <= 3'h0;
      end
      else
      begin
         stRd_r <= rdEn && addr[1:0] == 2'h2 && addr[4:2] != 3'h0;
         glRd_r <= rdEn && addr == 5'h02;
         rdBuf_r <= addr[4:2];
      end
   a_qempty_flag: assert property (
      glRd_r |-> rdData[2] == ($past(txqCount, 2) == 6'h00)) else $error("queue empty flag");
   a_qnotfull_flag: assert property (
      glRd_r |-> rdData[0] == ($past(txqCount, 2) <= {1'b0, $past(txqDepthCode, 2)}))
      else $error("queue not full flag");
   a_rx_txbits_zero: assert property (
      stRd_r && !bufCfg[rdBuf_r].isTx |-> rdData[7:4] == 4'h0) else $error("rx tx bits");
   a_tx_ovf_zero: assert property (
      stRd_r && bufCfg[rdBuf_r].isTx |-> !rdData[3]) else $error("tx overflow bit");
   a_index_range: assert property (
      stRd_r |-> rdData[12:8] <= bufCfg[rdBuf_r].depthCode) else $error("index range");
   a_payload_legal: assert property (
      $past(nrst) |-> bufCfg[1].payloadBytes inside
      {7'h08, 7'h0c, 7'h10, 7'h14, 7'h18, 7'h20, 7'h30, 7'h40}) else $error("payload bytes");
   a_abort_pulse: assert property (
      bufCfg[1].abortReq |-> bufCfg[1].isTx ##1 !bufCfg[1].abortReq) else $error("abort pulse");
   a_abort_clears_req: assert property (
      evt[1].abortDone |-> ##2 !bufCfg[1].sendRequest) else $error("request after abort");
endmodule

// ### tb/tb_cfmfc_top.sv
// self-checking bench for the message buffer control block
// assumes engine model and checker compiled before this file
`timescale 1ns/10ps
module tb_cfmfc_top;
   import cfmfc_pkg::*;
   localparam int NBUF = 7;
   localparam cfmfc_evt_t EV_RX = 7'h02;
   localparam cfmfc_evt_t EV_RTR = 7'h01;
   localparam cfmfc_evt_t EV_TX = 7'h40;
   localparam cfmfc_evt_t EV_TXE = 7'h50;
   localparam cfmfc_evt_t EV_ATT = 7'h04;
   logic                   clk = 1'b0;
   logic                   nrst = 1'b0;
   logic [4:0]             addr = 5'h00;
   logic [15:0]            wrData = 16'h0000;
   logic                   wrEn = 1'b0;
   logic                   rdEn = 1'b0;
   logic [15:0]            rdData;
   cfmfc_evt_t [NBUF:1]    evt;
   logic [5:0]             txqCount;
   logic [4:0]             txqDepthCode;
   cfmfc_bufcfg_t [NBUF:1] bufCfg;
   logic [2:0]             nextTxBuf;
   logic                   nextTxValid;
   int                     num_errors = 0;
   int                     n_compared = 0;
   int                     cyc = 0;
   logic [6:0]             bytesOf [8] = '{7'h08, 7'h0c, 7'h10, 7'h14, 7'h18, 7'h20, 7'h30, 7'h40};
   logic [15:0]            txLvl [4] = '{16'h0003, 16'h0003, 16'h0001, 16'h0000};

   always #4 clk = ~clk;

   cfmfc_top #(.NBUF(NBUF)) i_cfmfc_top (.clk(clk), .nrst(nrst), .addr(addr), .wrData(wrData),
      .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData), .evt(evt), .txqCount(txqCount),
      .txqDepthCode(txqDepthCode), .bufCfg(bufCfg), .nextTxBuf(nextTxBuf),
      .nextTxValid(nextTxValid));
   cfmfc_engine_model #(.NBUF(NBUF)) i_cfmfc_engine_model (.clk(clk), .bufCfg(bufCfg),
      .evt(evt), .txqCount(txqCount), .txqDepthCode(txqDepthCode));

   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      n_compared++;
      if (g !== e)
      begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wrData <= d;
      wrEn <= 1'b1;
      @(posedge clk);
      wrEn <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [4:0] a, output logic [15:0] d);
      @(posedge clk);
      addr <= a;
      rdEn <= 1'b1;
      @(posedge clk);
      rdEn <= 1'b0;
      @(negedge clk);
      d = rdData;
   endtask
   task automatic rdChk(input string n, input logic [4:0] a, input logic [15:0] e);
      logic [15:0] d;
      rd(a, d);
      chk(n, e, d);
   endtask
   task automatic waitCyc(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask
   task automatic ev(input int b, input cfmfc_evt_t e);
      i_cfmfc_engine_model.pulse(b, e);
   endtask

   task automatic t_reset();
      logic [15:0] d;
      d = 16'hffff;
      for (int i = 0; i < 8 && d[10] !== 1'b0; i++)
         rd(5'h05, d);
      chk("ctrl1", 16'h0000, d);
      rdChk("cfg1", 5'h04, 16'h0060);
      rdChk("stat1", 5'h06, 16'h0000);
      rdChk("unmapped", 5'h07, 16'h0000);
      rdChk("gstat0", 5'h02, 16'h0005);
      @(posedge clk);
      i_cfmfc_engine_model.txqCount <= 6'h04;
      waitCyc(3);
      rdChk("gstat4", 5'h02, 16'h0000);
      @(posedge clk);
      i_cfmfc_engine_model.txqCount <= 6'h02;
      waitCyc(3);
      rdChk("gstat2", 5'h02, 16'h0001);
      $display("t_reset done");
   endtask
   task automatic t_rx();
      wr(5'h08, 16'h0160);
      wr(5'h09, 16'h026f);
      waitCyc(2);
      chk("ts2", 16'h0001, {15'h0, bufCfg[2].tsEnable});
      chk("req2", 16'h0000, {15'h0, bufCfg[2].sendRequest});
      ev(2, EV_RX);
      rdChk("rx1", 5'h0a, 16'h0103);
      ev(2, EV_RX);
      rdChk("rx2", 5'h0a, 16'h0007);
      ev(2, EV_ATT);
      ev(2, EV_RX);
      rdChk("ovf", 5'h0a, 16'h000f);
      wr(5'h09, 16'h016f);
      rdChk("tail", 5'h0a, 16'h000b);
      wr(5'h0a, 16'h0000);
      rdChk("ovfclr", 5'h0a, 16'h0003);
      chk("irq2", 16'h0001, {15'h0, bufCfg[2].irq});
      wr(5'h09, 16'h0060);
      waitCyc(2);
      chk("irq2off", 16'h0000, {15'h0, bufCfg[2].irq});
      $display("t_rx done");
   endtask
   task automatic t_config();
      for (int c = 0; c < 8; c++)
      begin
         wr(5'h04, {c[2:0], 13'h0360});
         waitCyc(2);
         chk("payload_size", {9'h0, bytesOf[c]}, {9'h0, bufCfg[1].payloadBytes});
      end
      wr(5'h04, 16'hff3f);
      rdChk("cfgmax", 5'h04, 16'hff3f);
      chk("depth", 16'h001f, {11'h0, bufCfg[1].depthCode});
      chk("prio", 16'h001f, {11'h0, bufCfg[1].txPriority});
      wr(5'h04, 16'he33f);
      waitCyc(2);
      chk("retryoff", 16'h0002, {14'h0, bufCfg[1].retry});
      wr(5'h00, 16'h0008);
      waitCyc(2);
      chk("retry3", 16'h0001, {14'h0, bufCfg[1].retry});
      wr(5'h04, 16'h0000);
      rdChk("cfglock", 5'h04, 16'he300);
      chk("retry0", 16'h0000, {14'h0, bufCfg[1].retry});
      $display("t_config done");
   endtask
   task automatic t_tx();
      wr(5'h05, 16'h00c7);
      rdChk("txe", 5'h06, 16'h0007);
      chk("irq1", 16'h0001, {15'h0, bufCfg[1].irq});
      for (int i = 0; i < 4; i++)
      begin
         wr(5'h05, 16'h01c7);
         rdChk("inc", 5'h06, txLvl[i]);
      end
      ev(1, EV_RTR);
      waitCyc(2);
      chk("rtr", 16'h0001, {15'h0, bufCfg[1].sendRequest});
      ev(1, EV_TXE);
      rdChk("sent", 5'h06, 16'h0121);
      chk("msgidx", 16'h0001, {11'h0, bufCfg[1].msgIndex});
      chk("reqheld", 16'h0001, {15'h0, bufCfg[1].sendRequest});
      wr(5'h05, 16'h00c7);
      waitCyc(10);
      rdChk("abort", 5'h06, 16'h01c1);
      rdChk("abtrd", 5'h06, 16'h0141);
      ev(1, EV_ATT);
      rdChk("att", 5'h06, 16'h0151);
      wr(5'h06, 16'h0000);
      rdChk("attclr", 5'h06, 16'h0141);
      wr(5'h05, 16'h04c7);
      waitCyc(1);
      rdChk("rststat", 5'h06, 16'h0007);
      rdChk("rstctrl", 5'h05, 16'h00c7);
      $display("t_tx done");
   endtask
   task automatic t_prio();
      wr(5'h0c, 16'h0065);
      wr(5'h10, 16'h007e);
      // direction first: request and increment follow the direction already held
      wr(5'h0d, 16'h0080);
      wr(5'h11, 16'h0080);
      wr(5'h0d, 16'h0380);
      wr(5'h11, 16'h0380);
      waitCyc(3);
      chk("next4", 16'h000c, {12'h0, nextTxValid, nextTxBuf});
      ev(4, EV_TX);
      waitCyc(3);
      chk("next3", 16'h000b, {12'h0, nextTxValid, nextTxBuf});
      $display("t_prio done");
   endtask

   task automatic final_report();
      $display("compared %0d mismatched %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // cuts a hang well beyond the expected run length
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         num_errors++;
         final_report();
      end
   end

   initial
   begin
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      t_reset();
      t_rx();
      t_config();
      t_tx();
      t_prio();
      final_report();
   end
endmodule

bind cfmfc_top cfmfc_top_chk #(.NBUF(NBUF)) i_cfmfc_top_chk (.clk(clk), .nrst(nrst),
   .addr(addr), .rdEn(rdEn), .rdData(rdData), .evt(evt), .txqCount(txqCount),
   .txqDepthCode(txqDepthCode), .bufCfg(bufCfg));
